// ---- rtl/pfm_pkg.sv ----
// Pin function multiplexer: register offsets, field positions, pin map.
// Assumes a 16-bit byte address on the register port.
package pfm_pkg;
    localparam int          PFM_AW       = 16;
    localparam int          PFM_DW       = 32;
    localparam int          PFM_GW       = 32;
    localparam int          PFM_SW       = 16;
    // Byte offsets
    localparam logic [15:0] OFF_PINFUNC  = 16'h002C;
    localparam logic [15:0] OFF_TRIOUT   = 16'h0100;
    localparam logic [15:0] OFF_OUTSET   = 16'h0108;
    localparam logic [15:0] OFF_OUTCLR   = 16'h010C;
    localparam logic [15:0] OFF_PINSTATE = 16'h0110;
    // Pin function field positions
    localparam int          B_SSI0       = 0;
    localparam int          B_LINK       = 1;
    localparam int          B_IRTX       = 2;
    localparam int          B_UART0      = 3;
    localparam int          B_ETH0       = 4;
    localparam int          B_AUDIO      = 5;
    localparam int          B_ADIN       = 6;
    localparam int          B_FLOW3      = 7;
    localparam int          B_IRFAST     = 8;
    localparam int          B_CLK0       = 9;
    localparam int          B_CLK1       = 10;
    localparam int          B_ROMCKE     = 11;
    localparam int          B_UART1      = 12;
    localparam int          B_RSV        = 13;
    localparam int          B_UART3      = 14;
    localparam int          B_USB        = 15;
    localparam int          B_CSEL       = 16;
    localparam int          B_LCD        = 17;
    localparam int          B_CARD       = 18;
    localparam int          PF_W         = 19;
    localparam logic [18:0] PF_RST       = 19'h6703D;
    localparam logic [12:0] PF_ZERO      = 13'h0000;
    // Primary line numbers
    localparam int          GP_CLK0      = 2;
    localparam int          GP_CLK1      = 3;
    localparam int          GP_ROMCKE    = 6;
    localparam int          GP_ADIN      = 8;
    localparam int          GP_FLOW      = 9;
    localparam int          GP_FLOW_IN   = 11;
    localparam int          GP_IRFAST    = 15;
    localparam int          GP_ETH       = 24;
    localparam int          GP_ETH_EN    = 28;
    localparam int          GP_AUDIO     = 29;
    localparam int          GP_AUDIO_IO  = 31;
    // Secondary line indexes (line 200 + index)
    localparam int          SX_LCD       = 0;
    localparam int          SX_CARD      = 4;
    localparam int          SX_SSI0      = 8;
    localparam int          SX_IRTX      = 11;
    localparam int          SX_UART0     = 12;
    localparam int          SX_UART1     = 13;
    localparam int          SX_UART3     = 14;
    localparam int          SX_MDC       = 15;
endpackage : pfm_pkg

// ---- rtl/pfm_top.sv ----
// Pin function register, GPIO control registers and the pad multiplexer.
// Assumes a single-cycle register port and pads resolved outside.
//
// Overview of operation
// - A shared pin has one owner; peripheral ownership hides the GPIO line.
// - Pin function register returns to default on reset, runtime reset, sleep.
// - Pin function bits 31..19 read zero; software writes zero.
// - Bit 18 high routes card strobes, low routes GPIO lines.
// - Bit 17 low routes LCD_STROBE_SELECT strobes, high routes GPIO lines.
// - Bit 16 picks first external clock or 32k clock for bit 9.
// - Bit 15 connects USB pins to device or host root port.
// - Bits 14, 12, 3 low route UART3, UART1, UART0 transmit.
// - Bit 13 is reserved, writable, resets to one.
// - Bit 11 high routes ROM clock enable instead of line 6.
// - Bit 10 high routes second external clock instead of line 3.
// - Bit 9 high routes selected clock instead of line 2.
// - Bit 8 high routes infrared fast select instead of line 15.
// - Bit 7 high gives lines 14..9 to UART3 flow control.
// - Bit 6 high gives line 8 to audio data input.
// - Bit 5 low gives lines 31..29 to the audio serial port.
// - Bit 4 low gives Ethernet transmit and management clock pins.
// - Bit 2 low routes infrared transmit data.
// - Bit 1 picks audio link or second synchronous serial port.
// - Bit 0 low routes first synchronous serial port.
// - Separate set and clear writes change GPIO bits without read-modify.
// - Shared offsets read one register and write another; bit n is line n.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module pfm_top (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       runtime_rst,
    input  wire logic                       sleep_entry,
    input  wire logic [pfm_pkg::PFM_AW-1:0] reg_addr,
    input  wire logic [pfm_pkg::PFM_DW-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [pfm_pkg::PFM_DW-1:0] reg_rdata,
    input  wire logic [pfm_pkg::PFM_GW-1:0] gpio_pad_in,
    output logic      [pfm_pkg::PFM_GW-1:0] gpio_pad_out,
    output logic      [pfm_pkg::PFM_GW-1:0] gpio_pad_oe,
    output logic      [pfm_pkg::PFM_GW-1:0] gpio_line_in,
    input  wire logic [pfm_pkg::PFM_SW-1:0] sec_pad_in,
    output logic      [pfm_pkg::PFM_SW-1:0] sec_pad_out,
    output logic      [pfm_pkg::PFM_SW-1:0] sec_pad_oe,
    input  wire logic [pfm_pkg::PFM_SW-1:0] sec_gpio_out,
    input  wire logic [pfm_pkg::PFM_SW-1:0] sec_gpio_oe,
    output logic      [pfm_pkg::PFM_SW-1:0] sec_gpio_in,
    input  wire logic [3:0]                 card_strobes,
    input  wire logic [3:0]                 lcd_strobes,
    input  wire logic [2:0]                 ssi0_out,
    input  wire logic                       ir_tx,
    input  wire logic                       uart0_tx,
    input  wire logic                       uart1_tx,
    input  wire logic                       uart3_transmit,
    input  wire logic                       external_clock_first,
    input  wire logic                       external_clock_second,
    input  wire logic                       osc_32k,
    input  wire logic                       rom_clock_enable,
    input  wire logic                       ir_fast_mode_out,
    input  wire logic [1:0]                 uart3_flow_out,
    output logic      [3:0]                 uart3_flow_in,
    output logic                            audio_data_in,
    input  wire logic [1:0]                 audio_out,
    input  wire logic                       audio_dio_out,
    input  wire logic                       audio_dio_oe,
    output logic                            audio_dio_in,
    input  wire logic [3:0]                 eth0_txd,
    input  wire logic                       eth0_txen,
    input  wire logic                       eth0_mdc,
    input  wire logic [1:0]                 usb_dev_out,
    input  wire logic [1:0]                 usb_dev_oe,
    output logic      [1:0]                 usb_dev_in,
    input  wire logic [1:0]                 usb_host_out,
    input  wire logic [1:0]                 usb_host_oe,
    output logic      [1:0]                 usb_host_in,
    input  wire logic [1:0]                 usb_pad_in,
    output logic      [1:0]                 usb_pad_out,
    output logic      [1:0]                 usb_pad_oe,
    input  wire logic [3:0]                 ac97_out,
    input  wire logic [3:0]                 ac97_oe,
    output logic      [3:0]                 ac97_in,
    input  wire logic [3:0]                 ssi1_out,
    input  wire logic [3:0]                 ssi1_oe,
    output logic      [3:0]                 ssi1_in,
    input  wire logic [3:0]                 link_pad_in,
    output logic      [3:0]                 link_pad_out,
    output logic      [3:0]                 link_pad_oe
);
    import pfm_pkg::*;

    logic [PF_W-1:0]   pf;
    logic [PFM_GW-1:0] g_oe;
    logic [PFM_GW-1:0] g_out;
    logic              in_on;
    logic [PFM_GW-1:0] own;
    logic [PFM_GW-1:0] p_out;
    logic [PFM_GW-1:0] p_oe;
    logic [PFM_SW-1:0] s_own;
    logic [PFM_SW-1:0] s_out;
    logic [PFM_DW-1:0] next_rdata;
    logic [PFM_GW-1:0] pin_state;

    wire  wr_pf  = reg_wr && (reg_addr == OFF_PINFUNC);
    wire  wr_tri = reg_wr && (reg_addr == OFF_TRIOUT);
    wire  wr_set = reg_wr && (reg_addr == OFF_OUTSET);
    wire  wr_clr = reg_wr && (reg_addr == OFF_OUTCLR);
    wire  wr_ien = reg_wr && (reg_addr == OFF_PINSTATE);

    // Pin function register; runtime reset and sleep restore it too
    always_ff @(posedge clk) begin
        if (!nrst || runtime_rst || sleep_entry) begin
            pf <= PF_RST;
        end else if (wr_pf) begin
            pf <= reg_wdata[PF_W-1:0];
        end
    end

    // GPIO output enable and level; kept across runtime reset and sleep
    always_ff @(posedge clk) begin
        if (!nrst) begin
            g_oe <= '0;
        end else if (wr_tri) begin
            g_oe <= g_oe & ~reg_wdata;
        end else if (wr_set || wr_clr) begin
            g_oe <= g_oe | reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            g_out <= '0;
        end else if (wr_set) begin
            g_out <= g_out | reg_wdata;
        end else if (wr_clr) begin
            g_out <= g_out & ~reg_wdata;
        end
    end

    // Input enable: one write of zero per hardware reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            in_on <= 1'h0;
        end else if (wr_ien && !reg_wdata[0]) begin
            in_on <= 1'h1;
        end
    end

    // Primary lines: which are lent to a peripheral, and what it drives
    always_comb begin
        own   = '0;
        p_out = '0;
        p_oe  = '0;
        if (pf[B_CLK0]) begin
            own[GP_CLK0]   = 1'h1;
            p_oe[GP_CLK0]  = 1'h1;
            p_out[GP_CLK0] = pf[B_CSEL] ? osc_32k
                                        : external_clock_first;
        end
        if (pf[B_CLK1]) begin
            own[GP_CLK1]   = 1'h1;
            p_oe[GP_CLK1]  = 1'h1;
            p_out[GP_CLK1] = external_clock_second;
        end
        if (pf[B_ROMCKE]) begin
            own[GP_ROMCKE]   = 1'h1;
            p_oe[GP_ROMCKE]  = 1'h1;
            p_out[GP_ROMCKE] = rom_clock_enable;
        end
        if (pf[B_ADIN]) begin
            own[GP_ADIN] = 1'h1;
        end
        if (pf[B_IRFAST]) begin
            own[GP_IRFAST]   = 1'h1;
            p_oe[GP_IRFAST]  = 1'h1;
            p_out[GP_IRFAST] = ir_fast_mode_out;
        end
        if (pf[B_FLOW3]) begin
            own[GP_FLOW +: 6]   = 6'h3F;
            p_oe[GP_FLOW +: 2]  = 2'h3;
            p_out[GP_FLOW +: 2] = uart3_flow_out;
        end
        if (!pf[B_ETH0]) begin
            own[GP_ETH +: 5]   = 5'h1F;
            p_oe[GP_ETH +: 5]  = 5'h1F;
            p_out[GP_ETH +: 4] = eth0_txd;
            p_out[GP_ETH_EN]   = eth0_txen;
        end
        if (!pf[B_AUDIO]) begin
            own[GP_AUDIO +: 3]   = 3'h7;
            p_oe[GP_AUDIO +: 2]  = 2'h3;
            p_out[GP_AUDIO +: 2] = audio_out;
            p_oe[GP_AUDIO_IO]    = audio_dio_oe;
            p_out[GP_AUDIO_IO]   = audio_dio_out;
        end
    end

    // One owner per pad; a lent line shows nothing to the GPIO side
    assign gpio_pad_out = (own & p_out) | (~own & g_out);
    assign gpio_pad_oe  = (own & p_oe) | (~own & g_oe);
    assign gpio_line_in = {PFM_GW{in_on}} & ~own & gpio_pad_in;

    assign uart3_flow_in = pf[B_FLOW3] ? gpio_pad_in[GP_FLOW_IN +: 4]
                                       : 4'h0;
    assign audio_data_in = pf[B_ADIN] & gpio_pad_in[GP_ADIN];
    assign audio_dio_in  = ~pf[B_AUDIO] & gpio_pad_in[GP_AUDIO_IO];

    // Secondary lines
    always_comb begin
        s_own = '0;
        s_out = '0;
        if (!pf[B_LCD]) begin
            s_own[SX_LCD +: 4] = 4'hF;
            s_out[SX_LCD +: 4] = lcd_strobes;
        end
        if (pf[B_CARD]) begin
            s_own[SX_CARD +: 4] = 4'hF;
            s_out[SX_CARD +: 4] = card_strobes;
        end
        if (!pf[B_SSI0]) begin
            s_own[SX_SSI0 +: 3] = 3'h7;
            s_out[SX_SSI0 +: 3] = ssi0_out;
        end
        if (!pf[B_IRTX]) begin
            s_own[SX_IRTX] = 1'h1;
            s_out[SX_IRTX] = ir_tx;
        end
        if (!pf[B_UART0]) begin
            s_own[SX_UART0] = 1'h1;
            s_out[SX_UART0] = uart0_tx;
        end
        if (!pf[B_UART1]) begin
            s_own[SX_UART1] = 1'h1;
            s_out[SX_UART1] = uart1_tx;
        end
        if (!pf[B_UART3]) begin
            s_own[SX_UART3] = 1'h1;
            s_out[SX_UART3] = uart3_transmit;
        end
        if (!pf[B_ETH0]) begin
            s_own[SX_MDC] = 1'h1;
            s_out[SX_MDC] = eth0_mdc;
        end
    end

    assign sec_pad_out = s_out | (~s_own & sec_gpio_out);
    assign sec_pad_oe  = s_own | (~s_own & sec_gpio_oe);
    assign sec_gpio_in = ~s_own & sec_pad_in;

    // USB pair and the audio link / second serial port group
    assign usb_pad_out  = pf[B_USB] ? usb_host_out : usb_dev_out;
    assign usb_pad_oe   = pf[B_USB] ? usb_host_oe : usb_dev_oe;
    assign usb_host_in  = {2{pf[B_USB]}} & usb_pad_in;
    assign usb_dev_in   = {2{~pf[B_USB]}} & usb_pad_in;
    assign link_pad_out = pf[B_LINK] ? ssi1_out : ac97_out;
    assign link_pad_oe  = pf[B_LINK] ? ssi1_oe : ac97_oe;
    assign ssi1_in      = {4{pf[B_LINK]}} & link_pad_in;
    assign ac97_in      = {4{~pf[B_LINK]}} & link_pad_in;

    // Pin state shows driven level on outputs, sampled level on inputs once input enable is on, else zero
    assign pin_state = (gpio_pad_oe & gpio_pad_out)
                     | (~gpio_pad_oe & {PFM_GW{in_on}} & gpio_pad_in);

    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_PINFUNC:  next_rdata = {PF_ZERO, pf};
                OFF_TRIOUT:   next_rdata = g_oe;
                OFF_OUTSET:   next_rdata = g_out;
                OFF_PINSTATE: next_rdata = pin_state;
                default:      next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    property p_sleep_default;
        @(posedge clk) disable iff (!nrst)
        (sleep_entry || runtime_rst) |=> (pf == PF_RST);
    endproperty
    a_sleep_default: assert property (p_sleep_default)
        else $error("pin function not restored");

    property p_rsv_zero;
        @(posedge clk) disable iff (!nrst)
        (reg_rd && reg_addr == OFF_PINFUNC) |=> (reg_rdata[31:19] == 13'h0);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bits not zero");

    property p_owned_hidden;
        @(posedge clk) disable iff (!nrst)
        !pf[B_ETH0] |-> (gpio_line_in[GP_ETH +: 5] == 5'h0)
            && (gpio_pad_out[GP_ETH +: 4] == eth0_txd);
    endproperty
    a_owned_hidden: assert property (p_owned_hidden)
        else $error("owned line visible to GPIO");

    property p_card;
        @(posedge clk) disable iff (!nrst)
        sec_pad_out[SX_CARD +: 4] ==
            (pf[B_CARD] ? card_strobes : sec_gpio_out[SX_CARD +: 4]);
    endproperty
    a_card: assert property (p_card)
        else $error("card strobe routing wrong");

    property p_clk0;
        @(posedge clk) disable iff (!nrst)
        (pf[B_CLK0] && pf[B_CSEL]) |-> gpio_pad_out[GP_CLK0] == osc_32k;
    endproperty
    a_clk0: assert property (p_clk0)
        else $error("clock select wrong");

    property p_usb;
        @(posedge clk) disable iff (!nrst)
        pf[B_USB] |-> (usb_pad_out == usb_host_out) && (usb_dev_in == 2'h0);
    endproperty
    a_usb: assert property (p_usb)
        else $error("USB routing wrong");

    property p_set_clr;
        @(posedge clk) disable iff (!nrst)
        (wr_set || wr_clr) |=> ((g_out & $past(reg_wdata))
            == ($past(wr_set) ? $past(reg_wdata) : 32'h0));
    endproperty
    a_set_clr: assert property (p_set_clr)
        else $error("set or clear lost");

    property p_shared_read;
        @(posedge clk) disable iff (!nrst)
        (reg_rd && reg_addr == OFF_TRIOUT) |=> (reg_rdata == $past(g_oe));
    endproperty
    a_shared_read: assert property (p_shared_read)
        else $error("tristate read wrong");

    property p_adin;
        @(posedge clk) disable iff (!nrst)
        !pf[B_ADIN] |-> !audio_data_in;
    endproperty
    a_adin: assert property (p_adin)
        else $error("audio input leaks");
endmodule : pfm_top

// ---- verif/pfm_pad_model.sv ----
// Pads and board around the pin multiplexer: each pad reads back its
// own driven level, an undriven pad shows a fixed external pattern.
`timescale 1ns/100ps
module pfm_pad_model #(
    parameter logic [31:0] PAT = 32'hC35A_A53C
) (
    input  wire logic [31:0] g_out,
    input  wire logic [31:0] g_oe,
    output logic      [31:0] g_in,
    input  wire logic [15:0] s_out,
    input  wire logic [15:0] s_oe,
    output logic      [15:0] s_in,
    input  wire logic [1:0]  u_out,
    input  wire logic [1:0]  u_oe,
    output logic      [1:0]  u_in,
    input  wire logic [3:0]  l_out,
    input  wire logic [3:0]  l_oe,
    output logic      [3:0]  l_in
);
    // One driver per pad, the mux or the board, never both
    assign g_in = (g_oe & g_out) | (~g_oe & PAT);
    assign s_in = (s_oe & s_out) | (~s_oe & PAT[31:16]);
    assign u_in = (u_oe & u_out) | (~u_oe & PAT[1:0]);
    assign l_in = (l_oe & l_out) | (~l_oe & PAT[5:2]);
endmodule : pfm_pad_model

// ---- verif/testbench.sv ----
// Scenario bench for the pin function multiplexer.
// Assumes pfm_top and the pad model; software role is played here.
`timescale 1ns/100ps
module testbench;
    import pfm_pkg::*;
    localparam logic [31:0] PAT = 32'hC35A_A53C;
    localparam logic [87:0] PV  = 88'hA5_F00F_3C96_5AC3_E187_1E2D;
    localparam logic [31:0] M   = 32'h00F0_00B3;
    logic        clk, nrst, runtime_rst, sleep_entry, reg_wr, reg_rd, ien;
    logic [15:0] reg_addr, so, soe, sgi, spi;
    logic [31:0] reg_wdata, reg_rdata, go, ge, d;
    logic [31:0] gpo, gpe, gli, gpi;
    logic [87:0] pv;
    logic [3:0]  f3i, a97i, s1i, lpi, lpo, lpe;
    logic [1:0]  udi, uhi, upi, upo, upe;
    logic        adi, dioi;
    int          num_errors, n_compared;
    logic [18:0] tab [4] = '{19'h6703D, 19'h02000, 19'h7FFFF, 19'h02200};

    pfm_top pfm_top_inst (.clk(clk), .nrst(nrst),
        .runtime_rst(runtime_rst), .sleep_entry(sleep_entry),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_pad_in(gpi),
        .gpio_pad_out(gpo), .gpio_pad_oe(gpe), .gpio_line_in(gli),
        .sec_pad_in(spi), .sec_pad_out(so), .sec_pad_oe(soe),
        .sec_gpio_out(pv[71:56]), .sec_gpio_oe(pv[87:72]),
        .sec_gpio_in(sgi), .card_strobes(pv[3:0]),
        .lcd_strobes(pv[7:4]), .ssi0_out(pv[10:8]), .ir_tx(pv[11]),
        .uart0_tx(pv[12]), .uart1_tx(pv[13]), .uart3_transmit(pv[14]),
        .external_clock_first(pv[15]), .external_clock_second(pv[16]),
        .osc_32k(pv[17]), .rom_clock_enable(pv[18]),
        .ir_fast_mode_out(pv[19]), .uart3_flow_out(pv[21:20]),
        .uart3_flow_in(f3i), .audio_data_in(adi),
        .audio_out(pv[23:22]), .audio_dio_out(pv[24]),
        .audio_dio_oe(pv[25]), .audio_dio_in(dioi),
        .eth0_txd(pv[29:26]), .eth0_txen(pv[30]), .eth0_mdc(pv[31]),
        .usb_dev_out(pv[33:32]), .usb_dev_oe(pv[35:34]),
        .usb_dev_in(udi), .usb_host_out(pv[37:36]),
        .usb_host_oe(pv[39:38]), .usb_host_in(uhi), .usb_pad_in(upi),
        .usb_pad_out(upo), .usb_pad_oe(upe), .ac97_out(pv[43:40]),
        .ac97_oe(pv[47:44]), .ac97_in(a97i), .ssi1_out(pv[51:48]),
        .ssi1_oe(pv[55:52]), .ssi1_in(s1i), .link_pad_in(lpi),
        .link_pad_out(lpo), .link_pad_oe(lpe));

    pfm_pad_model #(.PAT(PAT)) pfm_pad_model_inst (.g_out(gpo),
        .g_oe(gpe), .g_in(gpi), .s_out(so), .s_oe(soe), .s_in(spi),
        .u_out(upo), .u_oe(upe), .u_in(upi), .l_out(lpo), .l_oe(lpe),
        .l_in(lpi));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Expected pad routing for pin function value p
    task automatic chk_mux(input logic [18:0] p);
        logic [15:0] sm, sp;
        logic [31:0] pm, pp, own, pmo;
        sp = {pv[31], pv[14:8], pv[3:0], pv[7:4]};
        sm = {~p[B_ETH0], ~p[B_UART3], ~p[B_UART1], ~p[B_UART0],
              ~p[B_IRTX], {3{~p[B_SSI0]}}, {4{p[B_CARD]}}, {4{~p[B_LCD]}}};
        pp = '0;
        pp[2] = p[B_CSEL] ? pv[17] : pv[15];
        pp[3] = pv[16];
        pp[6] = pv[18];
        pp[10:9] = pv[21:20];
        pp[15] = pv[19];
        pp[31:24] = {pv[24], pv[23:22], pv[30], pv[29:26]};
        pm = '0;
        pm[2] = p[B_CLK0];
        pm[3] = p[B_CLK1];
        pm[6] = p[B_ROMCKE];
        pm[10:9] = {2{p[B_FLOW3]}};
        pm[15] = p[B_IRFAST];
        pm[31:24] = {{3{~p[B_AUDIO]}}, {5{~p[B_ETH0]}}};
        own = pm;
        own[8] = p[B_ADIN];
        own[14:11] = {4{p[B_FLOW3]}};
        pmo = pm;
        pmo[31] = pm[31] & pv[25];
        check(32'(so), 32'((sm & sp) | (~sm & pv[71:56])));
        check(32'(soe), 32'(sm | (~sm & pv[87:72])));
        check(gpo, (pm & pp) | (~own & go));
        check(gpe, pmo | (~own & ge));
        check(gli, ien ? gpi & ~own : 32'h0);
        check(32'(adi), 32'(p[B_ADIN] & gpi[8]));
        check(32'(f3i), 32'(p[B_FLOW3] ? gpi[14:11] : 4'h0));
        check(32'(dioi), 32'(~p[B_AUDIO] & gpi[31]));
        check(32'(sgi), 32'(~sm & spi));
        check(32'(upo), 32'(p[B_USB] ? pv[37:36] : pv[33:32]));
        check(32'(upe), 32'(p[B_USB] ? pv[39:38] : pv[35:34]));
        check(32'({uhi, udi}),
              32'(p[B_USB] ? {upi, 2'h0} : {2'h0, upi}));
        check(32'(lpo), 32'(p[B_LINK] ? pv[51:48] : pv[43:40]));
        check(32'(lpe), 32'(p[B_LINK] ? pv[55:52] : pv[47:44]));
        check(32'({s1i, a97i}),
              32'(p[B_LINK] ? {lpi, 4'h0} : {4'h0, lpi}));
    endtask : chk_mux

    task automatic t_reset();
        rd(OFF_PINFUNC);
        check(d, {PF_ZERO, PF_RST});
        rd(OFF_TRIOUT);
        check(d, 32'h0);
        rd(OFF_OUTCLR);
        check(d, 32'h0);
        rd(16'h0200);
        check(d, 32'h0);
        chk_mux(PF_RST);
    endtask : t_reset

    task automatic t_pinfunc();
        for (int i = 0; i < 4; i++) begin
            // Reserved bits written zero, bit 13 written one
            wr(OFF_PINFUNC, 32'(tab[i]));
            rd(OFF_PINFUNC);
            check(d, {PF_ZERO, tab[i]});
            for (int j = 0; j < 2; j++) begin
                @(posedge clk);
                pv <= j[0] ? ~PV : PV;
                #1 chk_mux(tab[i]);
            end
        end
    endtask : t_pinfunc

    task automatic t_gpio();
        wr(OFF_OUTSET, 32'h00F0_00B0);
        go = go | 32'h00F0_00B0;
        ge = ge | 32'h00F0_00B0;
        wr(OFF_OUTCLR, 32'h0030_0011);
        go = go & ~32'h0030_0011;
        ge = ge | 32'h0030_0011;
        wr(OFF_TRIOUT, 32'h0080_0080);
        ge = ge & ~32'h0080_0080;
        rd(OFF_TRIOUT);
        check(d, ge);
        rd(OFF_OUTSET);
        check(d, go);
        wr(OFF_PINSTATE, 32'h1);
        rd(OFF_PINSTATE);
        check(d & M, ge & go & M);
        wr(OFF_PINSTATE, 32'h0);
        ien = 1'b1;
        rd(OFF_PINSTATE);
        check(d & M, ((ge & go) | (~ge & PAT)) & M);
        chk_mux(tab[3]);
    endtask : t_gpio

    task automatic t_retain();
        wr(OFF_PINFUNC, 32'h2000);
        @(posedge clk);
        runtime_rst <= 1'b1;
        @(posedge clk);
        runtime_rst <= 1'b0;
        rd(OFF_PINFUNC);
        check(d, {PF_ZERO, PF_RST});
        rd(OFF_TRIOUT);
        check(d, ge);
        @(posedge clk);
        reg_addr    <= OFF_PINFUNC;
        reg_wdata   <= 32'h2000;
        reg_wr      <= 1'b1;
        sleep_entry <= 1'b1;
        @(posedge clk);
        reg_wr      <= 1'b0;
        sleep_entry <= 1'b0;
        rd(OFF_PINFUNC);
        check(d, {PF_ZERO, PF_RST});
        rd(OFF_OUTSET);
        check(d, go);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        go = '0;
        ge = '0;
        ien = 1'b0;
        rd(OFF_TRIOUT);
        check(d, 32'h0);
        rd(OFF_PINSTATE);
        check(d & M, 32'h0);
        chk_mux(PF_RST);
    endtask : t_retain

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial begin
        {nrst, runtime_rst, sleep_entry, reg_wr, reg_rd, ien} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        go = '0;
        ge = '0;
        pv = PV;
        num_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_pinfunc();
        t_gpio();
        t_retain();
        conclude();
    end
endmodule : testbench
